/* oatf_pkg.sv */
// Package: operand addressing and test flag datapath constants and types
package oatf_pkg;
    // Operand size codes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // Address step per size
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    // Longword literal fetch masks the low two program counter bits
    localparam logic [31:0] PC_LONG_MASK = 32'hFFFF_FFFC;
    // Reset values
    localparam logic        TFLAG_RST = 1'h0;
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;
    // Addressing and operation codes from the decoder
    typedef enum logic [3:0] {
        OATF_OP_NONE   = 4'h0, // Idle, no operation
        OATF_OP_REG    = 4'h1, // Direct register operand
        OATF_OP_IND    = 4'h2, // Register indirect load
        OATF_OP_POST   = 4'h3, // Post-increment load
        OATF_OP_PRE    = 4'h4, // Pre-decrement load
        OATF_OP_LIT    = 4'h5, // Literal table load, pc relative
        OATF_OP_IDX    = 4'h6, // Indexed load, index plus base
        OATF_OP_IMM    = 4'h7, // Byte immediate from instruction word
        OATF_OP_ADD    = 4'h8, // Add register
        OATF_OP_ADDI   = 4'h9, // Add byte immediate
        OATF_OP_CMPGE  = 4'hA, // compare_signed_ge
        OATF_OP_CMPEQI = 4'hB, // compare_equal with immediate
        OATF_OP_BRTRUE  = 4'hC, // branch_if_true
        OATF_OP_BRFALSE = 4'hD  // branch_if_false
    } oatf_op_t;
    // Decoded request
    typedef struct packed {
        oatf_op_t    op;    // Operation
        logic [1:0]  size;  // Operand size
        logic [3:0]  sel_reg; // selected_general_register index
        logic [31:0] a;     // Value of selected register
        logic [31:0] b;     // Second register, base or index_register_zero
        logic [15:0] instr; // Instruction word
        logic [31:0] pc;    // Program counter
    } oatf_req_t;
    // Memory read request to load-store unit
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [1:0]  size;
    } oatf_mem_t;
    // Register write-back
    typedef struct packed {
        logic        valid;
        logic [3:0]  idx;
        logic [31:0] data;
    } oatf_wb_t;
    // Load sequencer state, one-hot encoded
    typedef enum logic [1:0] {
        OATF_ST_IDLE = 2'b01, // Accept requests
        OATF_ST_WAIT = 2'b10  // Awaiting load data
    } oatf_state_t;
endpackage

/* oatf_core.sv */
// Module: operand addressing, literal fetch and test flag datapath
`timescale 1ns/1ps
// What this block does
// - One test flag in status word drives branches
// - Signed ge compare sets flag; branches follow it
// - Add and add-immediate keep test flag
// - Equal-immediate compare sets or clears flag
// - Byte immediate comes from instruction word
// - Word/long constants loaded pc-relative from table
// - Absolute address: literal to register, then indirect
// - Large displacement: literal index plus base
// - Direct mode uses register, no memory access
// - Indirect address equals unmodified register
// - Post-increment: address then add 1/2/4
// - Pre-decrement: subtract 1/2/4, address, write back
// - Byte/word loads sign-extended to 32 bits
module oatf_core (
    input  wire logic              clk,        // Core clock
    input  wire logic              rst,        // Asynchronous reset, high
    input  wire logic              req_valid,  // Decoder request strobe
    input  oatf_pkg::oatf_req_t    req,        // Decoded request
    output logic                   req_ready,  // Can take a request
    output oatf_pkg::oatf_mem_t    mem_req,    // Load request to memory
    input  wire logic              mem_valid,  // Load data returned
    input  wire logic [31:0]       mem_rdata,  // Load data, low aligned
    output oatf_pkg::oatf_wb_t     addr_wb,    // Address register write-back
    output oatf_pkg::oatf_wb_t     data_wb,    // Data register write-back
    output logic                   t_flag,     // Test flag of status_word
    output logic                   branch_take,// Branch taken pulse
    output logic                   branch_ntk  // Branch not taken pulse
);
    // Size step for address arithmetic
    function automatic logic [31:0] step_of(input logic [1:0] sz);
        case (sz)
            oatf_pkg::SZ_BYTE: step_of = oatf_pkg::STEP_BYTE;
            oatf_pkg::SZ_WORD: step_of = oatf_pkg::STEP_WORD;
            default:           step_of = oatf_pkg::STEP_LONG;
        endcase
    endfunction
    // Sign extension of loaded data by size
    function automatic logic [31:0] sext(input logic [31:0] d, input logic [1:0] sz);
        case (sz)
            oatf_pkg::SZ_BYTE: sext = {{24{d[7]}}, d[7:0]};
            oatf_pkg::SZ_WORD: sext = {{16{d[15]}}, d[15:0]};
            default:           sext = d;
        endcase
    endfunction

    oatf_pkg::oatf_state_t st_r, st_nxt;       // Load sequencer state
    logic                  t_r, t_nxt;         // Test flag
    logic [3:0]            dst_r, dst_nxt;     // Pending load destination
    logic [1:0]            dsz_r, dsz_nxt;     // Pending load size
    oatf_pkg::oatf_mem_t   mem_r, mem_nxt;     // Memory request register
    oatf_pkg::oatf_wb_t    awb_r, awb_nxt;     // Address write-back register
    oatf_pkg::oatf_wb_t    dwb_r, dwb_nxt;     // Data write-back register
    logic                  tk_r, tk_nxt;       // Branch taken
    logic                  bn_r, bn_nxt;       // Branch not taken
    logic [31:0]           imm_s;              // Sign-extended byte immediate
    logic [31:0]           step_s;             // Size step
    logic [31:0]           pre_s;              // Pre-decremented address
    logic [31:0]           disp_s;             // Scaled literal displacement

    // Next-state logic for sequencer, flag and outputs
    always_comb begin
        st_nxt  = st_r;
        t_nxt   = t_r;
        dst_nxt = dst_r;
        dsz_nxt = dsz_r;
        mem_nxt = '0;
        awb_nxt = '0;
        dwb_nxt = '0;
        tk_nxt  = 1'b0;
        bn_nxt  = 1'b0;
        imm_s   = {{24{req.instr[7]}}, req.instr[7:0]};
        step_s  = step_of(req.size);
        pre_s   = req.a - step_s;
        disp_s  = (req.size == oatf_pkg::SZ_WORD) ? {23'h0, req.instr[7:0], 1'b0}
                                                  : {22'h0, req.instr[7:0], 2'b00};
        case (st_r)
            oatf_pkg::OATF_ST_IDLE: begin
                if (req_valid) begin
                    dst_nxt = req.sel_reg;
                    dsz_nxt = req.size;
                    case (req.op)
                        oatf_pkg::OATF_OP_REG: begin
                            // Operand is the register itself, no load
                            dwb_nxt = '{valid: 1'b1, idx: req.sel_reg, data: req.b};
                        end
                        oatf_pkg::OATF_OP_IND: begin
                            mem_nxt = '{valid: 1'b1, addr: req.a, size: req.size};
                            st_nxt  = oatf_pkg::OATF_ST_WAIT;
                        end
                        oatf_pkg::OATF_OP_POST: begin
                            mem_nxt = '{valid: 1'b1, addr: req.a, size: req.size};
                            awb_nxt = '{valid: 1'b1, idx: req.sel_reg, data: req.a + step_s};
                            st_nxt  = oatf_pkg::OATF_ST_WAIT;
                        end
                        oatf_pkg::OATF_OP_PRE: begin
                            mem_nxt = '{valid: 1'b1, addr: pre_s, size: req.size};
                            awb_nxt = '{valid: 1'b1, idx: req.sel_reg, data: pre_s};
                            st_nxt  = oatf_pkg::OATF_ST_WAIT;
                        end
                        oatf_pkg::OATF_OP_LIT: begin
                            // Literal table fetch, longword masks pc low bits
                            mem_nxt.valid = 1'b1;
                            mem_nxt.size  = req.size;
                            mem_nxt.addr  = ((req.size == oatf_pkg::SZ_WORD) ? req.pc
                                            : (req.pc & oatf_pkg::PC_LONG_MASK)) + disp_s;
                            st_nxt        = oatf_pkg::OATF_ST_WAIT;
                        end
                        oatf_pkg::OATF_OP_IDX: begin
                            mem_nxt = '{valid: 1'b1, addr: req.a + req.b, size: req.size};
                            st_nxt  = oatf_pkg::OATF_ST_WAIT;
                        end
                        oatf_pkg::OATF_OP_IMM: begin
                            dwb_nxt = '{valid: 1'b1, idx: req.sel_reg, data: imm_s};
                        end
                        oatf_pkg::OATF_OP_ADD: begin
                            // Flag untouched by addition
                            dwb_nxt = '{valid: 1'b1, idx: req.sel_reg, data: req.a + req.b};
                        end
                        oatf_pkg::OATF_OP_ADDI: begin
                            dwb_nxt = '{valid: 1'b1, idx: req.sel_reg, data: req.a + imm_s};
                        end
                        oatf_pkg::OATF_OP_CMPGE: begin
                            t_nxt = ($signed(req.a) >= $signed(req.b));
                        end
                        oatf_pkg::OATF_OP_CMPEQI: begin
                            t_nxt = (req.a == imm_s);
                        end
                        oatf_pkg::OATF_OP_BRTRUE: begin
                            tk_nxt = t_r;
                            bn_nxt = ~t_r;
                        end
                        oatf_pkg::OATF_OP_BRFALSE: begin
                            tk_nxt = ~t_r;
                            bn_nxt = t_r;
                        end
                        default: begin
                            st_nxt = oatf_pkg::OATF_ST_IDLE;
                        end
                    endcase
                end
            end
            oatf_pkg::OATF_ST_WAIT: begin
                // Wait for load data, then write extended value
                if (mem_valid) begin
                    dwb_nxt = '{valid: 1'b1, idx: dst_r, data: sext(mem_rdata, dsz_r)};
                    st_nxt  = oatf_pkg::OATF_ST_IDLE;
                end
            end
            default: begin
                st_nxt = oatf_pkg::OATF_ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r  <= oatf_pkg::OATF_ST_IDLE;
            t_r   <= oatf_pkg::TFLAG_RST;
            dst_r <= 4'h0;
            dsz_r <= oatf_pkg::SZ_BYTE;
            mem_r <= '0;
            awb_r <= '0;
            dwb_r <= '0;
            tk_r  <= 1'b0;
            bn_r  <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            t_r   <= t_nxt;
            dst_r <= dst_nxt;
            dsz_r <= dsz_nxt;
            mem_r <= mem_nxt;
            awb_r <= awb_nxt;
            dwb_r <= dwb_nxt;
            tk_r  <= tk_nxt;
            bn_r  <= bn_nxt;
        end
    end

    // Ready register: low while a load is outstanding
    logic rdy_r, rdy_nxt;
    always_comb begin
        rdy_nxt = (st_nxt == oatf_pkg::OATF_ST_IDLE);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdy_r <= 1'b1;
        end else begin
            rdy_r <= rdy_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign req_ready   = rdy_r;
    assign mem_req     = mem_r;
    assign addr_wb     = awb_r;
    assign data_wb     = dwb_r;
    assign t_flag      = t_r;
    assign branch_take = tk_r;
    assign branch_ntk  = bn_r;

    wire take_s = req_valid && (st_r == oatf_pkg::OATF_ST_IDLE);

    a_cmpge_sets_flag: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_CMPGE |=> t_flag == $past($signed(req.a) >= $signed(req.b)))
        else $error("compare ge flag wrong");
    a_add_keeps_flag: assert property (@(posedge clk) disable iff (rst)
        take_s && (req.op == oatf_pkg::OATF_OP_ADD || req.op == oatf_pkg::OATF_OP_ADDI) |=> $stable(t_flag))
        else $error("add changed test flag");
    a_cmpeq_sets_flag: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_CMPEQI |=> t_flag == ($past(req.a) == $past(imm_s)))
        else $error("compare equal flag wrong");
    a_branch_true: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_BRTRUE |=> branch_take == $past(t_flag) && branch_ntk != branch_take)
        else $error("branch if true wrong");
    a_branch_false: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_BRFALSE |=> branch_take == !$past(t_flag)
        && branch_ntk == $past(t_flag))
        else $error("branch if false wrong");
    a_reg_no_mem: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_REG |=> !mem_req.valid && data_wb.valid)
        else $error("direct mode made a load");
    a_ind_addr: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_IND |=> mem_req.valid && mem_req.addr == $past(req.a) && !addr_wb.valid)
        else $error("indirect address wrong");
    a_post_inc: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_POST |=>
        mem_req.addr == $past(req.a) && addr_wb.data == $past(req.a) + step_of($past(req.size)))
        else $error("post increment wrong");
    a_pre_dec: assert property (@(posedge clk) disable iff (rst)
        take_s && req.op == oatf_pkg::OATF_OP_PRE |=> mem_req.addr == addr_wb.data && addr_wb.valid
        && addr_wb.data == $past(req.a) - step_of($past(req.size)))
        else $error("pre decrement wrong");
    a_byte_sext: assert property (@(posedge clk) disable iff (rst)
        st_r == oatf_pkg::OATF_ST_WAIT && mem_valid && dsz_r == oatf_pkg::SZ_BYTE
        |=> data_wb.valid && data_wb.data == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
        else $error("byte sign extension wrong");
    c_post_load: cover property (@(posedge clk) take_s && req.op == oatf_pkg::OATF_OP_POST ##[1:5] mem_valid);
    c_lit_load: cover property (@(posedge clk) take_s && req.op == oatf_pkg::OATF_OP_LIT);
    c_cmp_branch: cover property (@(posedge clk) take_s && req.op == oatf_pkg::OATF_OP_CMPGE ##1
        take_s && req.op == oatf_pkg::OATF_OP_BRTRUE);
endmodule

/* oatf_lsu_model.sv */
// Load-store unit model answering load requests after a chosen latency
`timescale 1ns/1ps
module oatf_lsu_model (
    input  wire logic           clk,       // Core clock
    input  wire logic           rst,       // Asynchronous reset, high
    input  oatf_pkg::oatf_mem_t mem_req,   // Load request from the block
    input  wire logic [7:0]     lat,       // Cycles from request to data, less one, at least 1
    input  wire logic [31:0]    fill,      // Data returned for the next load
    output logic                mem_valid, // Load data pulse
    output logic [31:0]         mem_rdata  // Load data, garbage outside the pulse
);
    logic [7:0] cnt_r; // Remaining wait cycles, zero when idle

    // Count down the latency, pulse data once, scramble the bus otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r     <= 8'h00;
            mem_valid <= 1'b0;
            mem_rdata <= 32'h0000_0000;
        end else begin
            mem_valid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.valid) begin
                cnt_r <= lat;
            end else if (cnt_r == 8'h01) begin
                mem_valid <= 1'b1;
                mem_rdata <= fill;
                cnt_r     <= 8'h00;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule

/* test_operand_address_and_test_flag.sv */
// Self-checking bench for the operand addressing and test flag datapath
`timescale 1ns/1ps
module test_operand_address_and_test_flag;
    logic                clk, rst, req_valid, req_ready, mem_valid, t_flag, branch_take, branch_ntk;
    oatf_pkg::oatf_req_t req;
    oatf_pkg::oatf_mem_t mem_req;
    oatf_pkg::oatf_wb_t  addr_wb, data_wb;
    logic [31:0]         mem_rdata, fill;
    logic [7:0]          lat;
    int                  err_total, n_compared, cycles;

    oatf_core DUT (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .mem_req(mem_req), .mem_valid(mem_valid), .mem_rdata(mem_rdata), .addr_wb(addr_wb),
        .data_wb(data_wb), .t_flag(t_flag), .branch_take(branch_take), .branch_ntk(branch_ntk));
    oatf_lsu_model lsu (.clk(clk), .rst(rst), .mem_req(mem_req), .lat(lat), .fill(fill),
        .mem_valid(mem_valid), .mem_rdata(mem_rdata));

    // Clock at 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            $display("mismatch at %0t: run did not finish", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    function automatic oatf_pkg::oatf_req_t mk(input oatf_pkg::oatf_op_t op, input logic [1:0] sz,
        input logic [31:0] a, input logic [31:0] b, input logic [7:0] imm, input logic [31:0] pc);
        return '{op: op, size: sz, sel_reg: 4'h3, a: a, b: b, instr: {8'h00, imm}, pc: pc};
    endfunction

    // Expected register image of a loaded byte, word or longword
    function automatic logic [31:0] sext(input logic [1:0] sz, input logic [31:0] v);
        if (sz == oatf_pkg::SZ_BYTE) return {{24{v[7]}}, v[7:0]};
        if (sz == oatf_pkg::SZ_WORD) return {{16{v[15]}}, v[15:0]};
        return v;
    endfunction

    // Present a request at the falling edge; results are seen one cycle on
    task automatic send(input oatf_pkg::oatf_req_t r);
        req_valid = 1'b1;
        req       = r;
        @(posedge clk);
        @(negedge clk);
    endtask

    // Load through any memory mode, checking address, register update and data
    task automatic ld(input oatf_pkg::oatf_op_t op, input logic [1:0] sz, input logic [31:0] a,
        input logic [31:0] b, input logic [7:0] imm, input logic [31:0] pc, input logic [31:0] ea,
        input logic awv, input logic [31:0] awd, input logic [31:0] d, input logic [7:0] l);
        int n;
        fill = d;
        lat  = l;
        send(mk(op, sz, a, b, imm, pc));
        req_valid = 1'b0;
        chk1(mem_req.valid, 1'b1);
        chk32(mem_req.addr, ea);
        chk32({30'h0, mem_req.size}, {30'h0, sz});
        chk1(addr_wb.valid, awv);
        chk1(req_ready, 1'b0);
        if (awv) chk32({28'h0, addr_wb.idx}, 32'h0000_0003);
        if (awv) chk32(addr_wb.data, awd);
        n = 0;
        while (data_wb.valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk1(data_wb.valid, 1'b1);
        chk32(data_wb.data, sext(sz, d));
        chk32({28'h0, data_wb.idx}, 32'h0000_0003);
        chk1(req_ready, 1'b1);
    endtask

    // Non-memory operation: write-back, flag and branch outcome
    task automatic alu(input oatf_pkg::oatf_op_t op, input logic [31:0] a, input logic [31:0] b,
        input logic [7:0] imm, input logic wbv, input logic [31:0] wbd, input logic t, input logic [1:0] br);
        send(mk(op, oatf_pkg::SZ_LONG, a, b, imm, 32'h0000_0000));
        chk1(mem_req.valid, 1'b0);
        chk1(data_wb.valid, wbv);
        if (wbv) chk32(data_wb.data, wbd);
        if (wbv) chk32({28'h0, data_wb.idx}, 32'h0000_0003);
        chk1(t_flag, t);
        chk1(branch_take, br[1]);
        chk1(branch_ntk, br[0]);
    endtask

    task automatic t_modes();
        logic [31:0] st[3];
        st = '{oatf_pkg::STEP_BYTE, oatf_pkg::STEP_WORD, oatf_pkg::STEP_LONG};
        alu(oatf_pkg::OATF_OP_REG, 32'h0, 32'h8765_4321, 8'h00, 1'b1, 32'h8765_4321, 1'b0, 2'b00);
        alu(oatf_pkg::OATF_OP_IMM, 32'h0, 32'h0, 8'h80, 1'b1, 32'hFFFF_FF80, 1'b0, 2'b00);
        ld(oatf_pkg::OATF_OP_IND, oatf_pkg::SZ_WORD, 32'h0000_1000, 32'h0, 8'h00, 32'h0, 32'h0000_1000,
            1'b0, 32'h0, 32'h0000_8001, 8'h01);
        for (int i = 0; i < 3; i++) begin
            ld(oatf_pkg::OATF_OP_POST, i[1:0], 32'hFFFF_FFFC, 32'h0, 8'h00, 32'h0, 32'hFFFF_FFFC,
                1'b1, 32'hFFFF_FFFC + st[i], 32'h0000_00F1, 8'h04);
            ld(oatf_pkg::OATF_OP_PRE, i[1:0], 32'h0000_0001, 32'h0, 8'h00, 32'h0, 32'h0000_0001 - st[i],
                1'b1, 32'h0000_0001 - st[i], 32'hFFFF_7F7F, 8'h01);
        end
    endtask

    task automatic t_literal();
        ld(oatf_pkg::OATF_OP_LIT, oatf_pkg::SZ_WORD, 32'h0, 32'h0, 8'h10, 32'h0000_1002, 32'h0000_1022,
            1'b0, 32'h0, 32'h0000_1234, 8'h02);
        ld(oatf_pkg::OATF_OP_LIT, oatf_pkg::SZ_LONG, 32'h0, 32'h0, 8'h10, 32'h0000_1003, 32'h0000_1040,
            1'b0, 32'h0, 32'h1234_5678, 8'h02);
        ld(oatf_pkg::OATF_OP_IND, oatf_pkg::SZ_BYTE, 32'h1234_5678, 32'h0, 8'h00, 32'h0, 32'h1234_5678,
            1'b0, 32'h0, 32'h0000_0085, 8'h01);
        ld(oatf_pkg::OATF_OP_IDX, oatf_pkg::SZ_WORD, 32'h0000_2000, 32'h0000_1234, 8'h00, 32'h0,
            32'h0000_3234, 1'b0, 32'h0, 32'h0000_7FFF, 8'h03);
    endtask

    task automatic t_flags();
        alu(oatf_pkg::OATF_OP_CMPGE, 32'h0000_0005, 32'h0000_0005, 8'h00, 1'b0, 32'h0, 1'b1, 2'b00);
        alu(oatf_pkg::OATF_OP_BRTRUE, 32'h0, 32'h0, 8'h00, 1'b0, 32'h0, 1'b1, 2'b10);
        alu(oatf_pkg::OATF_OP_BRFALSE, 32'h0, 32'h0, 8'h00, 1'b0, 32'h0, 1'b1, 2'b01);
        alu(oatf_pkg::OATF_OP_ADD, 32'h0000_0001, 32'h0000_0002, 8'h00, 1'b1, 32'h0000_0003, 1'b1, 2'b00);
        alu(oatf_pkg::OATF_OP_CMPGE, 32'hFFFF_FFFF, 32'h0000_0001, 8'h00, 1'b0, 32'h0, 1'b0, 2'b00);
        alu(oatf_pkg::OATF_OP_BRTRUE, 32'h0, 32'h0, 8'h00, 1'b0, 32'h0, 1'b0, 2'b01);
        alu(oatf_pkg::OATF_OP_BRFALSE, 32'h0, 32'h0, 8'h00, 1'b0, 32'h0, 1'b0, 2'b10);
        alu(oatf_pkg::OATF_OP_ADDI, 32'hFFFF_FFFF, 32'h0, 8'h01, 1'b1, 32'h0000_0000, 1'b0, 2'b00);
        alu(oatf_pkg::OATF_OP_CMPEQI, 32'h0000_0000, 32'h0, 8'h00, 1'b0, 32'h0, 1'b1, 2'b00);
        alu(oatf_pkg::OATF_OP_BRTRUE, 32'h0, 32'h0, 8'h00, 1'b0, 32'h0, 1'b1, 2'b10);
        alu(oatf_pkg::OATF_OP_CMPEQI, 32'h0000_0080, 32'h0, 8'h80, 1'b0, 32'h0, 1'b0, 2'b00);
        alu(oatf_pkg::OATF_OP_CMPEQI, 32'hFFFF_FF80, 32'h0, 8'h80, 1'b0, 32'h0, 1'b1, 2'b00);
        // An idle operation code must leave the flag and every output alone
        alu(oatf_pkg::OATF_OP_NONE, 32'h0, 32'h0, 8'h00, 1'b0, 32'h0, 1'b1, 2'b00);
        req_valid = 1'b0;
    endtask

    initial begin
        err_total  = 0;
        n_compared = 0;
        cycles     = 0;
        rst        = 1'b1;
        req_valid  = 1'b0;
        req        = mk(oatf_pkg::OATF_OP_NONE, oatf_pkg::SZ_BYTE, 32'h0, 32'h0, 8'h00, 32'h0);
        lat        = 8'h01;
        fill       = 32'h0000_0000;
        repeat (12) @(negedge clk);
        chk1(req_ready, 1'b1);
        chk1(t_flag, oatf_pkg::TFLAG_RST);
        rst = 1'b0;
        t_modes();
        t_literal();
        t_flags();
        repeat (3) @(negedge clk);
        final_report();
    end
endmodule
